// ---- bench/clock_route_chk.sv ----
// assertions on the ports of the clock routing block
// assumes one clock, synchronous active-high power reset
`timescale 1ns/1ns
module clock_route_chk (
    // clock and power reset
    input wire logic        REF_CLK,
    input wire logic        RST,
    // bus
    input wire logic        HSEL,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    // straps and routing state
    input wire logic        NV_WDT_ENABLE,
    input wire logic        NV_WDT_ALWAYS_ON,
    input wire logic [75:0] ROUTE_GEN,
    input wire logic [18:0] ROUTE_ON,
    input wire logic [18:0] ROUTE_LOCK,
    input wire logic [8:0]  GEN_LOCKED
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // accepted transfers
    wire logic take = HSEL && HTRANS[1] && HREADY;
    wire logic rd_go = take && !HWRITE;
    wire logic wr_go = take && HWRITE;
    a_resp_okay: assert property (HRESP == 1'b0)
        else $error("error response seen");
    a_read_wait: assert property (rd_go |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read answer timing wrong");
    a_write_ready: assert property (wr_go |=> HREADYOUT)
        else $error("write stalled");
    a_rst_clear: assert property ($fell(RST) |-> ROUTE_LOCK == 19'h0
        && ROUTE_ON == 19'h0 && GEN_LOCKED == 9'h0)
        else $error("entries not cleared by power reset");
    a_wdt_init: assert property ($fell(RST) |-> ##[2:4]
        (ROUTE_GEN[15:12] == 4'h2 && ROUTE_ON[3] == NV_WDT_ENABLE
        && ROUTE_LOCK[3] == NV_WDT_ALWAYS_ON))
        else $error("watchdog entry not loaded");
    a_lock_keep: assert property (!$past(RST) |->
        (ROUTE_LOCK & $past(ROUTE_LOCK)) == $past(ROUTE_LOCK))
        else $error("lock bit cleared");
    a_on_frozen: assert property (!$past(RST) |->
        ((ROUTE_ON ^ $past(ROUTE_ON)) & $past(ROUTE_LOCK)) == 19'h0)
        else $error("locked route on changed");
    a_wdt_frozen: assert property (!$past(RST) && $past(ROUTE_LOCK[3])
        |-> $stable(ROUTE_GEN[15:12]))
        else $error("locked watchdog generator changed");
    a_gen0_free: assert property (GEN_LOCKED[0] == 1'b0)
        else $error("generator zero locked");
    // main scenarios
    c_read: cover property (rd_go);
    c_lock: cover property ($rose(ROUTE_LOCK[5]));
    c_user: cover property ($fell(ROUTE_ON[6]));
endmodule // clock_route_chk
bind clock_route clock_route_chk chk_i (.REF_CLK, .RST, .HSEL, .HTRANS,
    .HWRITE, .HREADY, .HREADYOUT, .HRESP, .NV_WDT_ENABLE, .NV_WDT_ALWAYS_ON,
    .ROUTE_GEN, .ROUTE_ON, .ROUTE_LOCK, .GEN_LOCKED);

// ---- bench/clock_route_tb.sv ----
// self-checking bench for the clock routing block
// assumes a lone ahb-lite master; straps change only around power reset
`timescale 1ns/1ns
module clock_route_tb
    import route_pkg::*;
;
    logic        REF_CLK = 1'b0, RST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, q;
    logic [1:0]  HTRANS = 2'h0;
    logic        HREADYOUT, HRESP, USER_RST_REQ = 1'b0;
    logic        NV_WDT_ENABLE = 1'b1, NV_WDT_ALWAYS_ON = 1'b0;
    logic [75:0] ROUTE_GEN;
    logic [18:0] ROUTE_ON, ROUTE_LOCK;
    logic [8:0]  GEN_LOCKED;
    gen_t        g;
    int          n_errors = 0, comparisons = 0;
    wire logic   HREADY = HREADYOUT; // one slave drives bus ready
    always #5 REF_CLK = ~REF_CLK;
    clock_route uut (.REF_CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE,
        .HSIZE(3'h2), .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP,
        .USER_RST_REQ, .NV_WDT_ENABLE, .NV_WDT_ALWAYS_ON, .ROUTE_GEN,
        .ROUTE_ON, .ROUTE_LOCK, .GEN_LOCKED);
    // routing word as software sees it
    function automatic logic [31:0] mk(chan_t i, gen_t gg, logic o, logic k);
        return {16'h0, k, o, 2'h0, gg, 2'h0, i};
    endfunction
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [75:0] seen, logic [75:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // bounded wait on ready, or on a channel switching off
    task automatic hold(int ch);
        int n;
        n = 0;
        do begin
            @(posedge REF_CLK);
            n++;
        end while ((ch < 0 ? HREADYOUT !== 1'b1 : ROUTE_ON[ch] !== 1'b0)
            && n < 50);
        if (n >= 50) begin
            n_errors++;
            test_done();
        end
    endtask
    // one single transfer, then an idle cycle
    task automatic xfer(logic w, logic [31:0] a, logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= w;
        hold(-1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        hold(-1);
        q = HRDATA;
        @(posedge REF_CLK);
    endtask
    task automatic por(logic en, logic ao);
        NV_WDT_ENABLE <= en;
        NV_WDT_ALWAYS_ON <= ao;
        RST <= 1'b1;
        repeat (2) @(posedge REF_CLK);
        RST <= 1'b0;
        repeat (5) @(posedge REF_CLK);
    endtask
    initial begin
        por(1'b1, 1'b0);
        chk("gen", ROUTE_GEN, 76'h2000);
        chk("on", ROUTE_ON, 19'h8);
        chk("lock", ROUTE_LOCK, 19'h0);
        $display("power reset test done");
        for (int i = 0; i < 20; i++) begin
            g = gen_t'(i % 8 + 1);
            xfer(1'b1, 32'h8, mk(chan_t'(i), g, 1'b1, 1'b0));
            xfer(1'b0, 32'h8, 32'h0);
            chk("word", q, mk(chan_t'(i), i < 19 ? g : 4'h0, i < 19, 1'b0));
            chk("gen pin", ROUTE_GEN[4*(i%19) +: 4], i < 19 ? g : 4'h1);
        end
        $display("index test done");
        xfer(1'b1, 32'h8, mk(6'h05, 4'h3, 1'b1, 1'b1));
        xfer(1'b1, 32'h8, mk(6'h05, 4'h1, 1'b0, 1'b0));
        xfer(1'b0, 32'h8, 32'h0);
        chk("locked word", q, mk(6'h05, 4'h3, 1'b1, 1'b1));
        chk("gen locks", GEN_LOCKED, 9'h008);
        xfer(1'b0, 32'h4, 32'h0);
        chk("status", q, 32'h0);
        xfer(1'b0, 32'h40, 32'h0);
        chk("unmapped", q, 32'h0);
        $display("lock test done");
        xfer(1'b1, 32'h0, 32'h1);
        hold(6);
        chk("user gen", ROUTE_GEN, 76'h352000);
        chk("user on", ROUTE_ON, 19'h38);
        chk("user lock", ROUTE_LOCK, 19'h20);
        xfer(1'b1, 32'h8, mk(6'h04, 4'h5, 1'b0, 1'b0));
        xfer(1'b1, 32'h8, mk(6'h06, 4'h1, 1'b1, 1'b0));
        USER_RST_REQ <= 1'b1;
        hold(6);
        USER_RST_REQ <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        chk("pin gen", ROUTE_GEN, 76'h302000);
        $display("user reset test done");
        por(1'b0, 1'b1);
        chk("gen", ROUTE_GEN, 76'h2000);
        chk("on", ROUTE_ON, 19'h0);
        chk("lock", ROUTE_LOCK, 19'h8);
        chk("gen locks", GEN_LOCKED, 9'h004);
        xfer(1'b1, 32'h8, mk(6'h03, 4'h7, 1'b1, 1'b0));
        chk("wdt held", ROUTE_GEN, 76'h2000);
        $display("always-on test done");
        test_done();
    end
endmodule // clock_route_tb

// ---- verilog/clock_route.sv ----
// generic clock routing table with an ahb-lite register slave
// assumes one master, whole-word single transfers, nv straps static pins
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "route_regs.svh"
module clock_route
    import route_pkg::*;
(
    // clock and power reset
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // user reset request and nonvolatile straps, asynchronous pins
    input  wire logic        USER_RST_REQ,
    input  wire logic        NV_WDT_ENABLE,
    input  wire logic        NV_WDT_ALWAYS_ON,
    // routing state
    output logic      [75:0] ROUTE_GEN,
    output logic      [18:0] ROUTE_ON,
    output logic      [18:0] ROUTE_LOCK,
    output logic      [8:0]  GEN_LOCKED
);
    route_cmd_if cmd ();

    // pin synchronisers: two flops per pin, only the second one is read
    logic [1:0] urst_sync_ff;
    logic [1:0] nven_sync_ff;
    logic [1:0] nvaon_sync_ff;

    // user reset request; a level, applied while it stays high
    always_ff @(posedge REF_CLK) begin
        urst_sync_ff <= {urst_sync_ff[0], USER_RST_REQ};
    end

    // watchdog enable strap; static, but asynchronous to this clock
    always_ff @(posedge REF_CLK) begin
        nven_sync_ff <= {nven_sync_ff[0], NV_WDT_ENABLE};
    end

    // watchdog always-on strap; static, but asynchronous to this clock
    always_ff @(posedge REF_CLK) begin
        nvaon_sync_ff <= {nvaon_sync_ff[0], NV_WDT_ALWAYS_ON};
    end

    // power reset settle counter: the strap synchronisers hold no reset,
    // so the watchdog entry waits until both flops carry the strap value
    logic [1:0] init_ff;
    wire        init_busy = (init_ff != 2'h0);
    wire        init_load = (init_ff == 2'h1);  // last count: load watchdog
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            init_ff <= `INIT_WAIT;
        end else if (init_busy) begin
            init_ff <= init_ff - 2'h1;
        end
    end

    // address phase capture; a transfer counts only when the bus is ready
    logic       dp_wr_ff;
    logic       dp_rd_ff;
    logic [7:0] dp_addr_ff;
    wire        ap_take = HSEL && HTRANS[1] && HREADY;
    wire        ap_rd   = ap_take && !HWRITE;
    wire        ap_wr   = ap_take && HWRITE;

    // data phase flags; the word address is kept, byte lanes ignored
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            dp_wr_ff   <= 1'b0;
            dp_rd_ff   <= 1'b0;
            dp_addr_ff <= 8'h00;
        end else begin
            dp_wr_ff   <= ap_wr;
            dp_rd_ff   <= ap_rd;
            if (ap_take) begin
                dp_addr_ff <= {HADDR[7:2], 2'b00};
            end
        end
    end

    // write decode in the data phase, where the write data stand
    wire wr_ctrl  = dp_wr_ff && (dp_addr_ff == `ADDR_CTRL);
    wire wr_route = dp_wr_ff && (dp_addr_ff == `ADDR_ROUTE);

    // user reset: control bit or synchronised pin, both act the same way
    wire sw_reset = wr_ctrl && HWDATA[`F_USER_RST];
    wire user_rst = sw_reset || urst_sync_ff[1];

    // selected channel index; a user reset points it back at channel 0
    chan_t index_ff;
    always_ff @(posedge REF_CLK) begin
        if (RST || user_rst) begin
            index_ff <= 6'h00;
        end else if (wr_route) begin
            index_ff <= HWDATA[`F_INDEX_HI:`F_INDEX_LO];
        end
    end

    // commands to the entries; every entry sees every write and
    // compares the index against its own code
    assign cmd.wr_en        = wr_route;
    assign cmd.wr_index     = HWDATA[`F_INDEX_HI:`F_INDEX_LO];
    assign cmd.wr_gen       = HWDATA[`F_GEN_HI:`F_GEN_LO];
    assign cmd.wr_on        = HWDATA[`F_ON];
    assign cmd.wr_lock      = HWDATA[`F_LOCK];
    assign cmd.user_rst     = user_rst;
    assign cmd.wdt_init     = init_load;
    assign cmd.nv_enable    = nven_sync_ff[1];
    assign cmd.nv_always_on = nvaon_sync_ff[1];

    // entry state
    gen_t gen_q [`NUM_CHANNELS];
    logic on_q  [`NUM_CHANNELS];
    logic lock_q[`NUM_CHANNELS];

    // one entry per channel; codes 0..18, kinds by code
    // only the watchdog and calendar entries differ on reset;
    // every other code, the pll timer one too, is a plain entry
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_CHANNELS; gi++) begin : g_ch
            localparam chan_t CHC = chan_t'(gi);
            localparam chan_kind_t KD =
                (CHC == `CH_WATCHDOG) ? KIND_WATCHDOG :
                (CHC == `CH_CALENDAR) ? KIND_CALENDAR :
                KIND_OTHER;                  // pll timer is plain
            route_entry #(.CH(CHC), .KIND(KD)) u_entry (
                .clk     (REF_CLK),
                .rst     (RST),
                .cmd     (cmd),
                .gen_ff  (gen_q[gi]),
                .on_ff   (on_q[gi]),
                .lock_ff (lock_q[gi])
            );
            assign ROUTE_GEN[gi*4 +: 4] = gen_q[gi];
            assign ROUTE_ON[gi]         = on_q[gi];
            assign ROUTE_LOCK[gi]       = lock_q[gi];
        end
    endgenerate

    // generator lock: set with a channel lock, never for generator 0;
    // codes past the table count as locked so no lock is set for them
    wire        ch_ok    = (cmd.wr_index <= `CH_EVENT_LAST);
    wire [4:0]  wr_slot  = cmd.wr_index[4:0];
    wire        ch_lock  = ch_ok ? lock_q[wr_slot] : 1'b1;
    wire        ch_open  = ch_ok && !ch_lock;
    wire        gen_ok   = (cmd.wr_gen != 4'h0) && (cmd.wr_gen < 4'h9);
    wire        lock_gen = wr_route && cmd.wr_lock && ch_open && gen_ok;
    wire        wdt_gl   = cmd.wdt_init && cmd.nv_always_on;
    logic [8:0] gen_lock_ff;

    // generator lock flops; only a power reset clears them
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            gen_lock_ff <= 9'h000;
        end else begin
            if (lock_gen) begin
                gen_lock_ff[cmd.wr_gen] <= 1'b1;
            end
            if (wdt_gl) begin
                gen_lock_ff[`GEN_WATCHDOG] <= 1'b1;
            end
        end
    end
    assign GEN_LOCKED = gen_lock_ff;

    // read mux for the selected entry; codes past the table read
    // back the index alone, with generator, on and lock as zero
    wire        sel_ok = (index_ff <= `CH_EVENT_LAST);
    wire [4:0]  sel    = index_ff[4:0];
    wire [15:0] route_word = sel_ok ?
        {lock_q[sel], on_q[sel], 2'b00, gen_q[sel], 2'b00, index_ff} :
        {10'h000, index_ff};

    // only the routing word reads back; control and status read zero
    wire [31:0] rd_data = (dp_addr_ff == `ADDR_ROUTE) ?
        {16'h0000, route_word} : 32'h0000_0000;

    // bus response: reads take one wait state so the read mux settles
    // behind the registered address; writes complete with no wait
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            HRDATA    <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            HREADYOUT <= !ap_rd;
            HRESP     <= 1'b0;                  // always okay
            if (dp_rd_ff) begin
                HRDATA <= rd_data;
            end
        end
    end
endmodule // clock_route

// ---- verilog/route_cmd_if.sv ----
// command carrier from the bus side to the per-channel routing entries
// assumes one driver (the top) and many readers (the entries)
`timescale 1ns/1ns
interface route_cmd_if;
    import route_pkg::*;
    logic  wr_en;
    chan_t wr_index;
    gen_t  wr_gen;
    logic  wr_on;
    logic  wr_lock;
    logic  user_rst;
    logic  wdt_init;
    logic  nv_enable;
    logic  nv_always_on;
    modport ctrl  (output wr_en, wr_index, wr_gen, wr_on, wr_lock,
                   user_rst, wdt_init, nv_enable, nv_always_on);
    modport entry (input  wr_en, wr_index, wr_gen, wr_on, wr_lock,
                   user_rst, wdt_init, nv_enable, nv_always_on);
endinterface // route_cmd_if

// ---- verilog/route_entry.sv ----
// one channel's routing entry: generator pick, route on, write lock
// assumes commands from route_cmd_if, same clock, synchronous reset
`timescale 1ns/1ns
`include "route_regs.svh"
module route_entry
    import route_pkg::*;
#(
    parameter chan_t      CH   = 6'h00,
    parameter chan_kind_t KIND = KIND_OTHER
) (
    // clock and power reset
    input  wire logic   clk,
    input  wire logic   rst,
    // commands
    route_cmd_if.entry  cmd,
    // entry state
    output gen_t        gen_ff,
    output logic        on_ff,
    output logic        lock_ff
);
    // this entry is addressed by a write that the lock does not block
    wire hit_wr = cmd.wr_en && (cmd.wr_index == CH) && !lock_ff;
    wire is_wdt = (KIND == KIND_WATCHDOG);
    wire is_cal = (KIND == KIND_CALENDAR);

    gen_t nxt_gen;
    logic nxt_on;
    logic nxt_lock;

    // next entry value
    always_comb begin
        nxt_gen  = gen_ff;
        nxt_on   = on_ff;
        nxt_lock = lock_ff;                      // user reset keeps it
        if (cmd.wdt_init && is_wdt) begin
            nxt_gen  = `GEN_WATCHDOG;
            nxt_on   = cmd.nv_enable;
            nxt_lock = cmd.nv_always_on;
        end else if (cmd.user_rst && !lock_ff) begin
            if (is_wdt) begin
                nxt_gen = `GEN_WATCHDOG;
                nxt_on  = cmd.nv_enable;
            end else if (is_cal) begin
                if (!on_ff) begin
                    nxt_gen = `GEN_RESET;
                    nxt_on  = `ROUTE_IDLE;
                end
            end else begin
                nxt_gen = `GEN_RESET;
                nxt_on  = `ROUTE_IDLE;
            end
        end else if (hit_wr) begin
            nxt_gen  = cmd.wr_gen;
            nxt_on   = cmd.wr_on;
            nxt_lock = cmd.wr_lock;
        end
    end

    // entry flops; power reset clears all, watchdog loaded after straps settle
    always_ff @(posedge clk) begin
        if (rst) begin
            gen_ff  <= `GEN_RESET;
            on_ff   <= `ROUTE_IDLE;
            lock_ff <= 1'b0;
        end else begin
            gen_ff  <= nxt_gen;
            on_ff   <= nxt_on;
            lock_ff <= nxt_lock;
        end
    end
endmodule // route_entry

// ---- verilog/route_pkg.sv ----
// types shared by the clock routing block
// assumes route_regs.svh is included by the design files
package route_pkg;
    typedef logic [3:0] gen_t;
    typedef logic [5:0] chan_t;
    typedef enum logic [1:0] {
        KIND_OTHER    = 2'b00,
        KIND_WATCHDOG = 2'b01,
        KIND_CALENDAR = 2'b10
    } chan_kind_t;
endpackage

// ---- verilog/route_regs.svh ----
// register offsets, field positions and reset values of the clock routing
// block; assumes a 32-bit word bus with one register per aligned word
// Behaviour
// - a six-bit channel index picks which routing entry an access touches
// - power reset clears every entry, calendar included; watchdog differs
// - user reset restores only unlocked entries, the calendar entry only while its route is off
// - after power reset watchdog picks generator two, on from nv enable
// - after power reset watchdog lock equals the nv always-on bit
// - user reset on unlocked watchdog: generator two, on from nv enable
// - index codes: fll 0, pll 1, watchdog 3, calendar 4, ... events 7-18
// - index two routes the slow lock-timer clock of the pll
// - a set lock blocks writes to its entry until power reset and flags its generator in GEN_LOCKED; only generators 1 to 8 get flagged
`ifndef ROUTE_REGS_SVH
`define ROUTE_REGS_SVH
// register indices as printed; byte address is four times the index
`define IDX_CTRL        2'h0
`define IDX_STATUS      2'h1
`define IDX_ROUTE       2'h2
`define ADDR_CTRL       8'h00
`define ADDR_STATUS     8'h04
`define ADDR_ROUTE      8'h08
// field positions of the routing word
`define F_INDEX_LO      0
`define F_INDEX_HI      5
`define F_GEN_LO        8
`define F_GEN_HI        11
`define F_ON            14
`define F_LOCK          15
`define F_USER_RST      0
// channel codes
`define CH_FLL_REF      6'h00
`define CH_PLL_REF      6'h01
`define CH_PLL_TIMER    6'h02
`define CH_WATCHDOG     6'h03
`define CH_CALENDAR     6'h04
`define CH_EXT_IRQ      6'h05
`define CH_SERIAL_BUS   6'h06
`define CH_EVENT_FIRST  6'h07
`define CH_EVENT_LAST   6'h12
`define NUM_CHANNELS    19
`define NUM_GENS        9
// reset values
`define GEN_RESET       4'h0
`define GEN_WATCHDOG    4'h2
`define ROUTE_IDLE      1'b0
// cycles after power reset before nv straps are trusted
`define INIT_WAIT       2'h3
`endif
